// ==== rtl/trace_consts.svh ====
/*
  Constants of the program-trace readout: debug-register command codes,
  field positions, item tags, reset values and cycle-count limits.
  Assumes it is included once by the trace package.
*/
`ifndef TRACE_CONSTS_SVH
`define TRACE_CONSTS_SVH

`define CMD_TRACE_CTRL      8'h61
`define CMD_TRACE_COMMAND   8'h62
`define CMD_TRACE_STATUS    8'h63
`define CMD_TRACE_DATA      8'h66

`define TCMD_CLEAR_BIT      3
`define TCMD_START_BIT      2
`define TCMD_STOP_BIT       1
`define TCMD_SAMPLE_BIT     0

`define TSTAT_STARTED_BIT   17
`define TSTAT_OVF_BIT       16
`define TSTAT_COUNT_MSB     15

`define CTRL_WIDTH          22
`define STATUS_RESET        18'h00000
`define READOUT_RESET       18'h00000

`define TAG_BRANCH          2'h0
`define TAG_PC              2'h1
`define TAG_DATA            2'h2
`define TAG_EVENT           2'h3

`define EV_SW               2'h0
`define EV_TIMESTAMP        2'h1
`define EV_XTRIG            2'h2
`define EV_EXC              2'h3

`define CC_SHORT_ONE        2'h1
`define CC_LONG             2'h3

`define BR_MAX              4'hC
`define PEND_DEPTH          12

`define CC_FULL_LIMIT       16'h8000
`define CC_FLOW_LIMIT       16'h2000
`define CC_SHORT_LIMIT      16'h0040
`define TS_MAX              14'h3FFF

`endif

// ==== rtl/trace_pkg.sv ====
/*
  Types shared by the trace readout modules: trace level, control
  register layout and the per-cycle execution record from the core.
  Assumes trace_consts.svh is on the include path.
*/
`default_nettype none
package trace_pkg;
  `include "trace_consts.svh"

  typedef enum logic [1:0] {
    LVL_COMPLETE = 2'h0,
    LVL_FLOW     = 2'h1,
    LVL_EVENT    = 2'h2,
    LVL_FLOW_CC  = 2'h3
  } level_t;

  typedef struct packed {
    logic [15:0] tracepoint;
    level_t      level;
    logic        full_halt;
    logic        save_pc;
    logic        save_load;
    logic        save_ret;
  } ctrl_t;

  typedef struct packed {
    logic        instr;
    logic        cond_branch;
    logic        taken;
    logic        pc_store;
    logic        is_call;
    logic        is_return;
    logic        load_valid;
    logic        load_long;
    logic [63:0] load_data;
    logic [63:0] pc;
    logic        sw_event;
    logic [13:0] sw_value;
    logic [7:0]  xtrig_events;
    logic        exc_valid;
    logic [4:0]  exc_cause;
    logic [14:0] machine_status_bits;
    logic [4:0]  dest_reg;
    logic        dest_written;
    logic [4:0]  exc_kind;
    logic        exc_taken;
    logic        is_load;
    logic        is_store;
    logic [3:0]  byte_en;
    logic [31:0] value;
    logic [31:0] addr;
  } trace_rec_t;
endpackage
`default_nettype wire

// ==== rtl/item_stream_if.sv ====
/*
  Valid/ready stream of trace items between the encoder, the buffer and
  the readout. Assumes both ends share one clock.
*/
`default_nettype none
interface item_stream_if #(parameter int W = 18);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== rtl/trace_item_fifo.sv ====
/*
  Trace buffer: first-word-fall-through FIFO with flush and fill count.
  Assumes DEPTH is a power of two and a single clock.
*/
`default_nettype none
module trace_item_fifo #(
  parameter int W     = 18,
  parameter int DEPTH = 16
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic                     flush,
  item_stream_if.rx                     in_s,
  item_stream_if.tx                     out_s,
  output logic [$clog2(DEPTH):0]        count
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } fstate_t;

  fstate_t s_reg;
  fstate_t s_next;
  logic    push;
  logic    pop;

  assign in_s.ready  = s_reg.cnt != (AW+1)'(DEPTH);
  assign out_s.valid = s_reg.cnt != '0;
  assign out_s.data  = s_reg.mem[s_reg.rp];
  assign count       = s_reg.cnt;

  always_comb begin
    s_next = s_reg;
    push   = in_s.valid && in_s.ready;
    pop    = out_s.valid && out_s.ready;
    if (push) begin
      s_next.mem[s_reg.wp] = in_s.data;
      s_next.wp = s_reg.wp + AW'(1);
    end
    if (pop) begin
      s_next.rp = s_reg.rp + AW'(1);
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush) begin
      s_next.wp  = '0;
      s_next.rp  = '0;
      s_next.cnt = '0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/trace_pin_sync.sv ====
/*
  Three-stage synchroniser for pin inputs; output follows once the
  second and third stages agree. Assumes raw inputs are asynchronous.
*/
`default_nettype none
module trace_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] raw,
  output logic [W-1:0]      level
);
  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] out;
  } sstate_t;

  sstate_t s_reg;
  sstate_t s_next;

  assign level = s_reg.out;

  always_comb begin
    s_next     = s_reg;
    s_next.ff1 = raw;
    s_next.ff2 = s_reg.ff1;
    s_next.ff3 = s_reg.ff2;
    for (int i = 0; i < W; i++) begin
      if (s_reg.ff2[i] == s_reg.ff3[i]) begin
        s_next.out[i] = s_reg.ff3[i];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/program_trace_readout.sv ====
/*
  Program-trace encoder and readout: packs execution records into 18-bit
  items, buffers them and serves the debug-register accesses for control,
  command, status and item readout.
  Assumes debug accesses and execution records arrive on clk; cross-trigger
  actions arrive as asynchronous pins.

//Behaviour
// RULE_01: Sample command copies the buffer item count into the status count field.
// RULE_02: Status bit 17 is set when tracing starts, cleared when it stops.
// RULE_03: Status bit 16 sets on cycle count overflow, cleared only by clear.
// RULE_04: Status bits 15:0 give the last sampled count, zero after reset.
// RULE_05: Writes to the status and item readout registers are ignored.
// RULE_06: Item readout shows the oldest unread item and advances after each read.
// RULE_07: The reader never reads more items than the sampled count.
// RULE_08: The reader collects all items of a multi-item entity before decoding.
// RULE_09: Complete trace gives eight items: cycles and status first, counter last.
// RULE_10: Complete items two and three carry register, exception and access fields.
// RULE_11: Branch item: tag 00, count N up to 12, leftmost N bits taken flags.
// RULE_12: Zero-branch items may appear on flush and are discarded by the decoder.
// RULE_13: Counter items tag 01, sixteen bits each, most significant first.
// RULE_14: Three counter items up to 48 bits, four up to 64, zero extended.
// RULE_15: Read data items tag 10: two items normally, four for long loads.
// RULE_16: Event items tag 11; subtype 00 carries the software event value.
// RULE_17: Cross-trigger event subtype 10 with one bit per event in 7:0.
// RULE_18: Exception event subtype 11 with cause in bits 4:0.
// RULE_19: Time-stamp event subtype 01 holds cycles since the previous stamp.
// RULE_20: Short cycle-count branch item: tag 00, count field, cycles then taken bit.
// RULE_21: Long cycle-count branch item: tag 00, 11, cycles 13:1, taken bit 0.
// RULE_22: Tracing stops as soon as the buffer is full, clearing the running bit.
// RULE_23: Clear command resets trace status and empties the buffer.
// RULE_24: Flow-with-cycle-count counter runs to 8192 cycles; beyond sets overflow.
// RULE_25: The buffer returns items strictly in stored order.
*/
`default_nettype none
module program_trace_readout #(
  parameter int ADDR_W     = 32,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic [7:0]          dbg_cmd,
  input  wire logic                dbg_wr,
  input  wire logic                dbg_rd,
  input  wire logic [21:0]         dbg_wdata,
  output logic [17:0]              dbg_rdata,
  output logic                     dbg_rvalid,
  input  wire logic                xtrig_stop_act,
  input  wire logic                xtrig_start_act,
  input  wire logic [15:0]         tracepoint_hit,
  input  wire logic                rec_valid,
  input  wire trace_pkg::trace_rec_t rec,
  output logic                     rec_ready,
  output logic                     trace_started_evt,
  output logic                     trace_stopped_evt,
  output logic                     dbg_halt_req
);
  import trace_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH);

  typedef struct packed {
    ctrl_t                          ctrl;
    logic                           started;
    logic                           ovf;
    logic [15:0]                    sampled;
    logic [17:0]                    rdata;
    logic                           rvalid;
    logic [`PEND_DEPTH-1:0][17:0]   pend;
    logic [3:0]                     pidx;
    logic [3:0]                     pcnt;
    logic [3:0]                     acc_n;
    logic [11:0]                    acc;
    logic [15:0]                    cyc;
    logic [13:0]                    ts;
    logic                           stop_lvl;
    logic                           start_lvl;
    logic                           started_evt;
    logic                           stopped_evt;
    logic                           halt;
  } state_t;

  function automatic logic [3:0] pc_items(input int aw);
    if (aw <= 32) begin
      return 4'h2;
    end else if (aw <= 48) begin
      return 4'h3;
    end
    return 4'h4;
  endfunction

  function automatic logic [63:0] addr_mask(input int aw);
    logic [63:0] m;
    m = '0;
    for (int i = 0; i < 64; i++) begin
      m[i] = i < aw;
    end
    return m;
  endfunction

  function automatic logic [17:0] branch_item(input logic [3:0] cnt, input logic [11:0] bits);
    return {`TAG_BRANCH, cnt, bits}; // RULE_11
  endfunction

  state_t          s_reg;
  state_t          s_next;
  state_t          n;
  logic [1:0]      act_level;
  logic [CW:0]     fifo_cnt;
  logic            fifo_flush;

  item_stream_if #(.W(18)) enc_if ();
  item_stream_if #(.W(18)) rd_if ();

  trace_pin_sync #(.W(2)) act_sync (
    .clk   (clk),
    .nrst  (nrst),
    .raw   ({xtrig_start_act, xtrig_stop_act}),
    .level (act_level)
  );

  trace_item_fifo #(.W(18), .DEPTH(FIFO_DEPTH)) buffer ( // RULE_25
    .clk   (clk),
    .nrst  (nrst),
    .flush (fifo_flush),
    .in_s  (enc_if.rx),
    .out_s (rd_if.tx),
    .count (fifo_cnt)
  );

  assign enc_if.valid      = s_reg.started && s_reg.pcnt != 4'h0;
  assign enc_if.data       = s_reg.pend[s_reg.pidx];
  assign rd_if.ready       = dbg_rd && dbg_cmd == `CMD_TRACE_DATA; // RULE_06
  assign rec_ready         = s_reg.pcnt == 4'h0;
  assign dbg_rdata         = s_reg.rdata;
  assign dbg_rvalid        = s_reg.rvalid;
  assign trace_started_evt = s_reg.started_evt;
  assign trace_stopped_evt = s_reg.stopped_evt;
  assign dbg_halt_req      = s_reg.halt;

  logic [`PEND_DEPTH-1:0][17:0] ls;
  logic [3:0]                   k;
  logic [15:0]                  cc;
  logic [63:0]                  pcm;
  logic [3:0]                   npc;
  logic                         take;
  logic                         cmd_wr;
  logic                         clear;
  logic                         start;
  logic                         stop;
  logic                         ovf_set;
  logic                         pc_need;
  logic                         ev_any;
  logic [3:0]                   an;
  logic [11:0]                  ab;

  always_comb begin
    n       = s_reg;
    ls      = '0;
    k       = 4'h0;
    cc      = (s_reg.cyc == 16'hFFFF) ? s_reg.cyc : s_reg.cyc + 16'h0001;
    pcm     = rec.pc & addr_mask(ADDR_W);
    npc     = pc_items(ADDR_W);
    take    = rec_valid && rec_ready && s_reg.started;
    cmd_wr  = dbg_wr && dbg_cmd == `CMD_TRACE_COMMAND;
    clear   = cmd_wr && dbg_wdata[`TCMD_CLEAR_BIT];
    ovf_set = 1'b0;
    ev_any  = rec.sw_event || rec.exc_valid || rec.xtrig_events != 8'h00;
    pc_need = 1'b0;
    an      = s_reg.acc_n;
    ab      = s_reg.acc;
    n.rvalid = 1'b0;

    // Only the control and command codes are decoded for writes
    if (dbg_wr && dbg_cmd == `CMD_TRACE_CTRL) begin // RULE_05
      n.ctrl = ctrl_t'(dbg_wdata);
    end
    if (cmd_wr && dbg_wdata[`TCMD_SAMPLE_BIT]) begin
      n.sampled = 16'(fifo_cnt); // RULE_01
    end
    if (dbg_rd && dbg_cmd == `CMD_TRACE_STATUS) begin
      n.rdata  = {s_reg.started, s_reg.ovf, s_reg.sampled}; // RULE_02 RULE_03 RULE_04
      n.rvalid = 1'b1;
    end
    if (rd_if.ready) begin
      n.rdata  = rd_if.valid ? rd_if.data : `READOUT_RESET; // RULE_06
      n.rvalid = 1'b1;
    end

    if (s_reg.started) begin
      n.cyc = cc;
      n.ts  = (s_reg.ts == `TS_MAX) ? s_reg.ts : s_reg.ts + 14'h0001;
    end

    if (take) begin
      unique case (s_reg.ctrl.level)
        LVL_COMPLETE: begin
          if (rec.instr) begin // RULE_09 RULE_10
            ls[0] = {(cc >= `CC_FULL_LIMIT) ? 15'h7FFF : cc[14:0],
                     rec.machine_status_bits[14:12]};
            ls[1] = {rec.machine_status_bits[11:0], rec.dest_reg, rec.dest_written};
            ls[2] = {rec.exc_kind, rec.exc_taken, rec.is_load, rec.is_store,
                     rec.byte_en, rec.value[31:26]};
            ls[3] = rec.value[25:8];
            ls[4] = {rec.value[7:0], rec.addr[31:22]};
            ls[5] = rec.addr[21:4];
            ls[6] = {rec.addr[3:0], rec.pc[31:18]};
            ls[7] = rec.pc[17:0];
            k     = 4'h8;
            n.cyc = 16'h0000;
            ovf_set = cc >= `CC_FULL_LIMIT;
          end
        end
        LVL_FLOW, LVL_FLOW_CC: begin
          pc_need = rec.pc_store || ev_any || (s_reg.ctrl.save_ret && rec.is_return) ||
                    (s_reg.ctrl.save_pc && rec.cond_branch && rec.taken);
          if (rec.cond_branch && s_reg.ctrl.level == LVL_FLOW) begin
            ab[4'hB - an] = rec.taken; // RULE_11
            an = an + 4'h1;
          end
          if (rec.cond_branch && s_reg.ctrl.level == LVL_FLOW_CC) begin
            if (cc < `CC_SHORT_LIMIT) begin
              ls[k] = {`TAG_BRANCH, `CC_SHORT_ONE, cc[5:0], rec.taken, 7'h00}; // RULE_20
            end else begin
              ls[k] = {`TAG_BRANCH, `CC_LONG,
                       (cc >= `CC_FLOW_LIMIT) ? 13'h1FFF : cc[12:0], rec.taken}; // RULE_21
            end
            k       = k + 4'h1;
            ovf_set = cc >= `CC_FLOW_LIMIT; // RULE_24
            n.cyc   = 16'h0000;
          end
          if (an != 4'h0 && (an == `BR_MAX || pc_need ||
              (s_reg.ctrl.save_load && rec.load_valid))) begin
            ls[k] = branch_item(an, ab);
            k     = k + 4'h1;
            an    = 4'h0;
            ab    = 12'h000;
          end
          if (s_reg.ctrl.save_load && rec.load_valid) begin // RULE_15
            for (int i = 0; i < 4; i++) begin
              if (rec.load_long) begin
                ls[k] = {`TAG_DATA, rec.load_data[16*(3-i) +: 16]};
                k     = k + 4'h1;
              end else if (i < 2) begin
                ls[k] = {`TAG_DATA, rec.load_data[16*(1-i) +: 16]};
                k     = k + 4'h1;
              end
            end
          end
        end
        LVL_EVENT: begin
          pc_need = (s_reg.ctrl.save_pc && rec.is_call) ||
                    (s_reg.ctrl.save_ret && rec.is_return);
          if (ev_any) begin
            ls[k] = {`TAG_EVENT, `EV_TIMESTAMP, s_reg.ts}; // RULE_19
            k     = k + 4'h1;
            n.ts  = 14'h0000;
          end
        end
      endcase

      if (pc_need) begin // RULE_13 RULE_14
        for (int i = 0; i < 4; i++) begin
          if (4'(i) < npc) begin
            ls[k] = {`TAG_PC, pcm[16*(int'(npc)-1-i) +: 16]};
            k     = k + 4'h1;
          end
        end
      end
      if (s_reg.ctrl.level != LVL_COMPLETE) begin
        if (rec.sw_event) begin
          ls[k] = {`TAG_EVENT, `EV_SW, rec.sw_value}; // RULE_16
          k     = k + 4'h1;
        end
        if (rec.xtrig_events != 8'h00) begin
          ls[k] = {`TAG_EVENT, `EV_XTRIG, 6'h00, rec.xtrig_events}; // RULE_17
          k     = k + 4'h1;
        end
        if (rec.exc_valid) begin
          ls[k] = {`TAG_EVENT, `EV_EXC, 9'h000, rec.exc_cause}; // RULE_18
          k     = k + 4'h1;
        end
      end
      n.acc_n = an;
      n.acc   = ab;
      if (k != 4'h0) begin
        n.pend = ls;
        n.pidx = 4'h0;
        n.pcnt = k;
      end
    end

    if (enc_if.valid && enc_if.ready) begin
      n.pidx = s_reg.pidx + 4'h1;
      n.pcnt = s_reg.pcnt - 4'h1;
    end

    n.stop_lvl  = act_level[0];
    n.start_lvl = act_level[1];
    start = (cmd_wr && dbg_wdata[`TCMD_START_BIT]) || (act_level[1] && !s_reg.start_lvl) ||
            ((tracepoint_hit & s_reg.ctrl.tracepoint) != 16'h0000);
    stop  = (cmd_wr && dbg_wdata[`TCMD_STOP_BIT]) || (act_level[0] && !s_reg.stop_lvl) ||
            (s_reg.started && !enc_if.ready) || clear; // RULE_22 RULE_23
    if (stop) begin
      n.started = 1'b0; // RULE_02
    end else if (start) begin
      n.started = 1'b1; // RULE_02
    end
    if (n.started && !s_reg.started) begin
      n.cyc   = 16'h0000;
      n.ts    = 14'h0000;
      n.acc_n = 4'h0;
      n.acc   = 12'h000;
    end
    if (!n.started) begin
      n.pcnt = 4'h0;
    end

    // A new overflow in the clearing cycle survives the clear
    n.ovf = ovf_set || (s_reg.ovf && !clear); // RULE_03 RULE_24
    if (clear) begin // RULE_23
      n.sampled = 16'h0000;
      n.acc_n   = 4'h0;
      n.acc     = 12'h000;
    end

    n.started_evt = n.started && !s_reg.started;
    n.stopped_evt = !n.started && s_reg.started;
    n.halt        = s_reg.ctrl.full_halt && (!enc_if.ready || s_reg.ovf);
  end

  assign fifo_flush = dbg_wr && dbg_cmd == `CMD_TRACE_COMMAND &&
                      dbg_wdata[`TCMD_CLEAR_BIT]; // RULE_23
  assign s_next     = n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule
`default_nettype wire

// ==== dv/trace_readout_props.sv ====
/* Port checker of the trace readout.
   Assumes it is bound to program_trace_readout. */
`default_nettype none
module trace_readout_props (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [7:0]  dbg_cmd,
  input wire logic        dbg_wr,
  input wire logic        dbg_rd,
  input wire logic [21:0] dbg_wdata,
  input wire logic [17:0] dbg_rdata,
  input wire logic        dbg_rvalid,
  input wire logic        rec_ready,
  input wire logic        trace_started_evt,
  input wire logic        trace_stopped_evt,
  input wire logic        dbg_halt_req
);
  logic run_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) run_reg <= 1'b0;
    else if (trace_started_evt) run_reg <= 1'b1;
    else if (trace_stopped_evt) run_reg <= 1'b0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_status_answer;
    dbg_rd && dbg_cmd == 8'h63 |=> dbg_rvalid;
  endproperty
  a_status_answer: assert property (p_status_answer)
    else $error("no status answer");
  property p_item_answer;
    dbg_rd && dbg_cmd == 8'h66 |=> dbg_rvalid;
  endproperty
  a_item_answer: assert property (p_item_answer)
    else $error("no item answer");
  property p_write_silent;
    dbg_wr && !dbg_rd |=> !dbg_rvalid;
  endproperty
  a_write_silent: assert property (p_write_silent)
    else $error("write answered");
  property p_rdata_hold;
    !$past(dbg_rd) |-> $stable(dbg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved");
  property p_clear_halt;
    dbg_wr && dbg_cmd == 8'h62 && dbg_wdata[3] |-> ##[2:3] !dbg_halt_req;
  endproperty
  a_clear_halt: assert property (p_clear_halt)
    else $error("halt after clear");
  property p_start;
    dbg_wr && dbg_cmd == 8'h62 && dbg_wdata[3:1] == 3'b010 && !run_reg && !trace_started_evt
      |-> ##1 trace_started_evt;
  endproperty
  a_start: assert property (p_start)
    else $error("start missed");
  property p_stop;
    dbg_wr && dbg_cmd == 8'h62 && dbg_wdata[1] && run_reg && !trace_stopped_evt
      |-> ##1 trace_stopped_evt;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop missed");
  property p_stop_drops;
    trace_stopped_evt |-> rec_ready;
  endproperty
  a_stop_drops: assert property (p_stop_drops)
    else $error("items pending after stop");
endmodule
bind program_trace_readout trace_readout_props trace_readout_props_inst (
  .clk(clk), .nrst(nrst), .dbg_cmd(dbg_cmd), .dbg_wr(dbg_wr), .dbg_rd(dbg_rd),
  .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata), .dbg_rvalid(dbg_rvalid),
  .rec_ready(rec_ready), .trace_started_evt(trace_started_evt),
  .trace_stopped_evt(trace_stopped_evt), .dbg_halt_req(dbg_halt_req));
`default_nettype wire

// ==== dv/dbg_host.sv ====
/* Debug host: register accesses on the falling edge.
   Assumes rvalid one cycle after the read edge. */
`default_nettype none
module dbg_host (
  input  wire logic        clk,
  input  wire logic [17:0] dbg_rdata,
  input  wire logic        dbg_rvalid,
  output logic [7:0]       dbg_cmd,
  output logic             dbg_wr,
  output logic             dbg_rd,
  output logic [21:0]      dbg_wdata,
  output logic             tmo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    dbg_cmd   = 8'h00;
    dbg_wr    = 1'b0;
    dbg_rd    = 1'b0;
    dbg_wdata = 22'h000000;
    tmo       = 1'b0;
  end
  task automatic wr(input logic [7:0] c, input logic [21:0] d);
    dbg_cmd   = c;
    dbg_wdata = d;
    dbg_wr    = 1'b1;
    @(negedge clk);
    dbg_wr    = 1'b0;
    dbg_wdata = ~d;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] c, output logic [17:0] q);
    dbg_cmd = c;
    dbg_rd  = 1'b1;
    @(negedge clk);
    dbg_rd  = 1'b0;
    dbg_cmd = ~c;
    for (int i = 0; i < 4 && dbg_rvalid !== 1'b1; i++) @(negedge clk);
    if (dbg_rvalid !== 1'b1) tmo = 1'b1;
    q = dbg_rdata;
    @(negedge clk);
  endtask
  // Sample, then read the sampled count
  task automatic drain(output logic [17:0] st, output logic [17:0] q[$]);
    logic [17:0] v;
    q = {};
    wr(8'h62, 22'h000001);
    rd(8'h63, st);
    repeat (st[15:0]) begin
      rd(8'h66, v);
      q.push_back(v);
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
/* Trace readout bench: host model on the debug side,
   records driven in place of the core. */
`default_nettype none
module tb;
  import trace_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, nrst, dbg_wr, dbg_rd, dbg_rvalid, rec_valid, rec_ready, tmo, xstop, xstart;
  logic [7:0]  dbg_cmd;
  logic [21:0] dbg_wdata;
  logic [17:0] dbg_rdata, st, v;
  logic [17:0] q[$];
  trace_rec_t  r;
  int          n_mismatch, n_tests;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  program_trace_readout program_trace_readout_inst (
    .clk(clk), .nrst(nrst), .dbg_cmd(dbg_cmd), .dbg_wr(dbg_wr), .dbg_rd(dbg_rd),
    .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata), .dbg_rvalid(dbg_rvalid),
    .xtrig_stop_act(xstop), .xtrig_start_act(xstart), .tracepoint_hit(16'h0000),
    .rec_valid(rec_valid), .rec(r), .rec_ready(rec_ready), .trace_started_evt(),
    .trace_stopped_evt(), .dbg_halt_req());
  dbg_host dbg_host_inst (.clk(clk), .dbg_rdata(dbg_rdata), .dbg_rvalid(dbg_rvalid),
    .dbg_cmd(dbg_cmd), .dbg_wr(dbg_wr), .dbg_rd(dbg_rd), .dbg_wdata(dbg_wdata), .tmo(tmo));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge tmo) begin
    n_mismatch++;
    results();
  end
  task automatic wait_ready();
    for (int i = 0; i < 40 && rec_ready !== 1'b1; i++) @(negedge clk);
    if (rec_ready !== 1'b1) begin
      n_mismatch++;
      results();
    end
  endtask
  task automatic send();
    wait_ready();
    rec_valid = 1'b1;
    @(negedge clk);
    rec_valid = 1'b0;
    wait_ready();
  endtask
  task automatic cmd(input logic [21:0] d);
    dbg_host_inst.wr(8'h62, d);
  endtask
  task automatic t_complete();
    dbg_host_inst.rd(8'h63, v);
    chk(64'(v), 64'h0);
    dbg_host_inst.rd(8'h66, v);
    chk(64'(v), 64'h0);
    cmd(22'h000004);
    dbg_host_inst.rd(8'h63, v);
    chk(64'(v[17]), 64'h1);
    r = '0;
    r.instr = 1'b1;
    r.machine_status_bits = 15'h5A3C;
    r.dest_reg = 5'h13;
    r.dest_written = 1'b1;
    r.exc_kind = 5'h0B;
    r.is_load = 1'b1;
    r.value = 32'hC0DE5AA5;
    r.addr = 32'h87654321;
    r.pc = 64'hABCD1234;
    send();
    r.pc = 64'h02468ACE;
    send();
    dbg_host_inst.wr(8'h63, 22'h3FFFFF);
    dbg_host_inst.wr(8'h66, 22'h3FFFFF);
    dbg_host_inst.drain(st, q);
    chk(64'(st), 64'h10);
    chk(64'(q[0][2:0]), 64'(r.machine_status_bits[14:12]));
    chk(64'(q[1]), 64'({r.machine_status_bits[11:0], r.dest_reg, r.dest_written}));
    chk(64'(q[2]), 64'({r.exc_kind, 3'b010, r.byte_en, r.value[31:26]}));
    chk(64'({q[3], q[4], q[5]}), 64'({r.value[25:0], r.addr[31:4]}));
    chk(64'({q[6], q[7]}), 64'({r.addr[3:0], 32'hABCD1234}));
    chk(64'({q[14][13:0], q[15]}), 64'(r.pc[31:0]));
    $display("complete test done");
  endtask
  task automatic t_flow();
    cmd(22'h000008);
    dbg_host_inst.wr(8'h61, 22'h000012);
    cmd(22'h000004);
    r = '0;
    r.cond_branch = 1'b1;
    for (int i = 0; i < 3; i++) begin
      r.taken = (i != 1);
      send();
    end
    r = '0;
    r.load_valid = 1'b1;
    r.load_data = 64'hA5C31E0F;
    r.pc_store = 1'b1;
    r.pc = 64'h12345678;
    r.sw_event = 1'b1;
    r.sw_value = 14'h02AB;
    r.xtrig_events = 8'h5A;
    send();
    cmd(22'h000002);
    dbg_host_inst.drain(st, q);
    chk(64'(st), 64'h7);
    chk(64'(q[0]), 64'h03A00);
    chk(64'({q[1], q[2]}), 64'({2'b10, 16'hA5C3, 2'b10, 16'h1E0F}));
    chk(64'({q[3], q[4]}), 64'({2'b01, 16'h1234, 2'b01, 16'h5678}));
    chk(64'(q[5]), 64'({4'hC, 14'h02AB}));
    chk(64'({q[6][17:14], q[6][7:0]}), 64'h E5A);
    cmd(22'h000004);
    r = '0;
    r.pc_store = 1'b1;
    r.exc_valid = 1'b1;
    for (int i = 0; i < 4; i++) begin
      r.exc_cause = 5'h09 + 5'(i);
      send();
    end
    dbg_host_inst.drain(st, q);
    for (int i = 0; i < 4; i++) begin
      chk(64'({q[3*i+2][17:14], q[3*i+2][4:0]}), 64'({4'hF, 5'h09 + 5'(i)}));
    end
    $display("flow test done");
  endtask
  task automatic t_cc();
    cmd(22'h000008);
    dbg_host_inst.wr(8'h61, 22'h000030);
    cmd(22'h000004);
    r = '0;
    r.cond_branch = 1'b1;
    r.taken = 1'b1;
    send();
    repeat (8300) @(negedge clk);
    r.taken = 1'b0;
    send();
    dbg_host_inst.drain(st, q);
    chk(64'(st[16]), 64'h1);
    chk(64'({q[0][17:14], q[0][7]}), 64'h03);
    chk(64'({q[1][17:14], q[1][0]}), 64'h06);
    cmd(22'h000008);
    dbg_host_inst.drain(st, q);
    dbg_host_inst.rd(8'h66, v);
    chk(64'({st, v, 18'(q.size())}), 64'h0);
    $display("cycle test done");
  endtask
  task automatic t_event();
    dbg_host_inst.wr(8'h61, 22'h000020);
    xstart = 1'b1;
    repeat (8) @(negedge clk);
    xstart = 1'b0;
    dbg_host_inst.rd(8'h63, v);
    chk(64'(v[17]), 64'h1);
    r = '0;
    r.instr = 1'b1;
    r.sw_event = 1'b1;
    r.sw_value = 14'h1357;
    send();
    xstop = 1'b1;
    repeat (8) @(negedge clk);
    xstop = 1'b0;
    dbg_host_inst.drain(st, q);
    chk(64'({st[17], q[0][17:14], q[1]}), 64'({1'b0, 4'hD, 4'hC, 14'h1357}));
    $display("event test done");
  endtask
  initial begin
    nrst       = 1'b0;
    rec_valid  = 1'b0;
    r          = '0;
    xstop      = 1'b0;
    xstart     = 1'b0;
    n_mismatch = 0;
    n_tests    = 0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    t_complete();
    t_flow();
    t_cc();
    t_event();
    results();
  end
endmodule
`default_nettype wire
